// ### rtl/css_clock_source.sv
//////////////////////////////////////////////////////////////////////////////////////////////////
// Overview of operation
// [RULE_01] - Crystal modes count 1024 input pin cycles before the clock counts as usable.
// [RULE_02] - Count starts after power-on reset plus any power-up delay, and on wake.
// [RULE_03] - Program counter frozen and execution held while the count runs.
// [RULE_04] - Multiplier on if config or software bit set; config set ignores software.
// [RULE_05] - Multiplier takes external or internal source and offers result as clock.
// [RULE_06] - Auxiliary timer crystal is a run-time selectable system clock.
// [RULE_07] - In RC and internal modes, config bit picks clock output or GPIO on out pin.
// [RULE_08] - Internal-oscillator mode frees the oscillator input pin for GPIO.
// [RULE_09] - Internal block is system clock by config default or software source select.
// [RULE_10] - Fast 16 MHz source is the 500 kHz mid oscillator through its own PLL.
// [RULE_11] - Software trim adjusts both fast and mid internal oscillators.
// [RULE_12] - Slow 31 kHz oscillator is uncalibrated and ignores the trim.
// [RULE_13] - Fast oscillator feeds postscaler and mux steered by four-bit select.
// [RULE_14] - Nine frequencies derive from mid oscillator via the four-bit select.
// [RULE_15] - Fast on when select picks it and config is internal or source is 1x.
// [RULE_16] - Mid on when select picks it and config is internal or source is 1x.
// [RULE_17] - Fast start-up oscillator runs first, before switching to fast oscillator.
// [RULE_18] - Fast running flag set while the fast oscillator runs.
// [RULE_19] - Fast near-lock flag set within 2% of final frequency.
// [RULE_20] - Fast stable flag set within 0.5% of final frequency.
// [RULE_21] - Mid running flag set while the mid oscillator runs.
// [RULE_22] - External-clock modes skip the crystal count and start at once.
// [RULE_23] - Source select 01 uses the auxiliary timer crystal as system clock.
// [RULE_24] - Any reset loads the frequency select with 0111, meaning 500 kHz.
// [RULE_25] - Oscillator flags are read-only and clear while their oscillator is off.
// [RULE_26] - Count completion and flags are synchronised before use.
//
// Our own choices: the address map and register access over Avalon-MM.
module css_clock_source #(
	parameter int ADDR_W = 4
) (
	input  wire logic                            clock,
	input  wire logic                            resetn,
	// Avalon-MM slave.
	input  wire logic [ADDR_W-1:0]               avs_address,
	input  wire logic                            avs_read,
	input  wire logic                            avs_write,
	input  wire logic [31:0]                     avs_writedata,
	input  wire logic [3:0]                      avs_byteenable,
	output logic [31:0]                          avs_readdata,
	output logic                                 avs_waitrequest,
	// Nonvolatile configuration.
	input  wire logic [2:0]                      cfg_source_select,
	input  wire logic                            cfg_multiplier_enable,
	input  wire logic                            cfg_clock_out_enable,
	// Start-up events.
	input  wire logic                            power_up_delay_enable,
	input  wire logic                            power_up_delay_expired,
	input  wire logic                            wake_event,
	input  wire logic                            osc_in_pin,
	// Analog oscillator status.
	input  wire css_pkg::css_osc_flags_s         osc_flags_raw,
	// Clock tree control.
	output css_pkg::css_osc_enables_s            osc_enables,
	output css_pkg::css_src_e                    system_clock_source,
	output logic [3:0]                           postscaler_select,
	output logic                                 multiplier_enable,
	output logic                                 multiplier_input_internal,
	output logic [5:0]                           fast_mid_trim,
	output logic                                 cpu_hold,
	output logic                                 crystal_clock_ready,
	output logic                                 osc_out_drives_clock,
	output logic                                 osc_out_is_gpio,
	output logic                                 osc_in_is_gpio
);

	//////////////////////////////////////////////////////////////////////////////////////////////
	// Software state.

	localparam int SYNC_LEN = css_pkg::SYNC_STAGES;
	localparam logic [css_pkg::SETTLE_W-1:0] SETTLE_LAST =
		css_pkg::SETTLE_W'(css_pkg::CRYSTAL_SETTLE_EDGES - 1);

	logic [3:0]             internal_freq_select;
	logic [1:0]             system_source_select;
	logic                   sw_multiplier_enable;
	logic [5:0]             freq_trim_reg;
	logic                   bus_ack;
	logic                   bus_req;
	logic                   hit_control;
	logic                   hit_status;
	logic                   hit_trim;
	css_pkg::css_osc_flags_s flags_meta;
	css_pkg::css_osc_flags_s flags_sync;
	css_pkg::css_osc_flags_s clock_status_reg;
	logic [SYNC_LEN-1:0]    pin_sync;
	logic                   pin_prev;
	logic                   pin_rise;
	css_pkg::css_state_e    state;
	css_pkg::css_state_e    next_state;
	logic [css_pkg::SETTLE_W-1:0] crystal_settle_counter;
	logic                   crystal_mode;
	logic                   internal_active;
	logic                   freq_slow;
	logic                   freq_mid;
	logic                   freq_fast;
	logic                   settle_done;
	logic [31:0]            control_word;
	logic [31:0]            status_word;
	logic [31:0]            trim_word;

	//////////////////////////////////////////////////////////////////////////////////////////////
	// Avalon-MM slave: one wait state on every access, so each request completes on the second
	// edge. Unmapped reads return zero and unmapped writes are dropped.

	assign bus_req         = avs_read | avs_write;
	assign avs_waitrequest = bus_req & ~bus_ack;
	assign hit_control     = (avs_address == css_pkg::OFS_CONTROL);
	assign hit_status      = (avs_address == css_pkg::OFS_STATUS);
	assign hit_trim        = (avs_address == css_pkg::OFS_TRIM);

	always_ff @(posedge clock) begin
		if (!resetn) begin
			bus_ack <= 1'b0;
		end else begin
			bus_ack <= bus_req & ~bus_ack;
		end
	end

	always_comb begin
		control_word = 32'h0000_0000;
		control_word[css_pkg::CTL_SRC_LSB +: 2]  = system_source_select;
		control_word[css_pkg::CTL_FREQ_LSB +: 4] = internal_freq_select;
		control_word[css_pkg::CTL_MULT_BIT]      = sw_multiplier_enable;
	end

	always_comb begin
		status_word = 32'h0000_0000;
		status_word[css_pkg::STA_MID_RUN_BIT]    = clock_status_reg.mid_osc_running;
		status_word[css_pkg::STA_FAST_STAB_BIT]  = clock_status_reg.fast_osc_stable;
		status_word[css_pkg::STA_FAST_LOCK_BIT]  = clock_status_reg.fast_osc_near_lock;
		status_word[css_pkg::STA_FAST_RUN_BIT]   = clock_status_reg.fast_osc_running;
		status_word[css_pkg::STA_XTAL_READY_BIT] = crystal_clock_ready;
		status_word[css_pkg::STA_CPU_HOLD_BIT]   = cpu_hold;
	end

	assign trim_word = {26'h000_0000, freq_trim_reg};

	// Read data are captured on the first cycle of the access and stand on the completing edge.
	always_ff @(posedge clock) begin
		if (!resetn) begin
			avs_readdata <= 32'h0000_0000;
		end else if (avs_read && !bus_ack) begin
			if (hit_control) begin
				avs_readdata <= control_word;
			end else if (hit_status) begin
				avs_readdata <= status_word; // [RULE_25]
			end else if (hit_trim) begin
				avs_readdata <= trim_word;
			end else begin
				avs_readdata <= 32'h0000_0000;
			end
		end
	end

	// Control register; the frequency select returns to 500 kHz on any reset.
	always_ff @(posedge clock) begin
		if (!resetn) begin
			internal_freq_select <= css_pkg::RST_FREQ_SELECT; // [RULE_24]
			system_source_select <= css_pkg::RST_SOURCE_SEL;
			sw_multiplier_enable <= css_pkg::RST_SW_MULT;
		end else if (avs_write && bus_ack && hit_control && avs_byteenable[0]) begin
			internal_freq_select <= avs_writedata[css_pkg::CTL_FREQ_LSB +: 4];
			system_source_select <= avs_writedata[css_pkg::CTL_SRC_LSB +: 2]; // [RULE_09]
			sw_multiplier_enable <= avs_writedata[css_pkg::CTL_MULT_BIT];
		end
	end

	always_ff @(posedge clock) begin
		if (!resetn) begin
			freq_trim_reg <= css_pkg::RST_TRIM;
		end else if (avs_write && bus_ack && hit_trim && avs_byteenable[0]) begin
			freq_trim_reg <= avs_writedata[5:0];
		end
	end

	//////////////////////////////////////////////////////////////////////////////////////////////
	// Synchronisers. The first stage feeds only the second, so metastability cannot leak into
	// the edge detector or the status register.

	always_ff @(posedge clock) begin
		if (!resetn) begin
			flags_meta <= '0;
			flags_sync <= '0;
		end else begin
			flags_meta <= osc_flags_raw; // [RULE_26]
			flags_sync <= flags_meta;
		end
	end

	always_ff @(posedge clock) begin
		if (!resetn) begin
			pin_sync <= '0;
			pin_prev <= 1'b0;
		end else begin
			pin_sync <= {pin_sync[SYNC_LEN-2:0], osc_in_pin}; // [RULE_26]
			pin_prev <= pin_sync[SYNC_LEN-1];
		end
	end

	assign pin_rise = pin_sync[SYNC_LEN-1] & ~pin_prev;

	// Flags are hardware-owned and forced low while their oscillator is disabled.
	always_ff @(posedge clock) begin
		if (!resetn) begin
			clock_status_reg <= '0;
		end else begin
			clock_status_reg.fast_osc_running   <= flags_sync.fast_osc_running
				& osc_enables.fast_osc_enable; // [RULE_18] [RULE_25]
			clock_status_reg.fast_osc_near_lock <= flags_sync.fast_osc_near_lock
				& osc_enables.fast_osc_enable; // [RULE_19] [RULE_25]
			clock_status_reg.fast_osc_stable    <= flags_sync.fast_osc_stable
				& osc_enables.fast_osc_enable; // [RULE_20] [RULE_25]
			clock_status_reg.mid_osc_running    <= flags_sync.mid_osc_running
				& osc_enables.mid_osc_enable; // [RULE_21] [RULE_25]
		end
	end

	//////////////////////////////////////////////////////////////////////////////////////////////
	// Crystal start-up sequencing.

	assign crystal_mode = (cfg_source_select == css_pkg::CFG_LOW_POWER_XTAL)
		| (cfg_source_select == css_pkg::CFG_MEDIUM_XTAL)
		| (cfg_source_select == css_pkg::CFG_HIGH_XTAL);
	assign settle_done  = pin_rise && (crystal_settle_counter == SETTLE_LAST);

	always_comb begin
		next_state = state;
		case (state)
			css_pkg::ST_POWER_UP: begin
				if (power_up_delay_enable) begin
					next_state = css_pkg::ST_DELAY; // [RULE_02]
				end else if (crystal_mode) begin
					next_state = css_pkg::ST_SETTLE;
				end else begin
					next_state = css_pkg::ST_RUN; // [RULE_22]
				end
			end
			css_pkg::ST_DELAY: begin
				if (power_up_delay_expired) begin
					next_state = crystal_mode ? css_pkg::ST_SETTLE : css_pkg::ST_RUN; // [RULE_02]
				end
			end
			css_pkg::ST_SETTLE: begin
				if (settle_done) begin
					next_state = css_pkg::ST_RUN; // [RULE_01]
				end
			end
			css_pkg::ST_RUN: begin
				if (wake_event && crystal_mode) begin
					next_state = css_pkg::ST_SETTLE; // [RULE_02]
				end
			end
			default: begin
				next_state = css_pkg::ST_POWER_UP;
			end
		endcase
	end

	always_ff @(posedge clock) begin
		if (!resetn) begin
			state <= css_pkg::ST_POWER_UP;
		end else begin
			state <= next_state;
		end
	end

	// In SETTLE the counter advances only on synchronised rising edges of the crystal input pin; outside SETTLE it clears to zero.
	always_ff @(posedge clock) begin
		if (!resetn) begin
			crystal_settle_counter <= '0;
		end else if (state != css_pkg::ST_SETTLE) begin
			crystal_settle_counter <= '0;
		end else if (pin_rise) begin
			crystal_settle_counter <= crystal_settle_counter + 1'b1; // [RULE_01]
		end
	end

	// Hold is registered so the processor sees a clean level; it drops on the same edge that enters RUN.
	always_ff @(posedge clock) begin
		if (!resetn) begin
			cpu_hold            <= 1'b1;
			crystal_clock_ready <= 1'b0;
		end else begin
			cpu_hold            <= (next_state != css_pkg::ST_RUN); // [RULE_03] [RULE_26]
			crystal_clock_ready <= (next_state == css_pkg::ST_RUN) & crystal_mode; // [RULE_01]
		end
	end

	//////////////////////////////////////////////////////////////////////////////////////////////
	// Internal oscillator enables and source selection.

	assign internal_active = (cfg_source_select == css_pkg::CFG_INTERNAL)
		| system_source_select[1];
	assign freq_slow = (internal_freq_select == css_pkg::FREQ_SLOW_CODE);
	assign freq_mid  = (internal_freq_select >= css_pkg::FREQ_MID_FIRST)
		& (internal_freq_select <= css_pkg::FREQ_MID_LAST); // [RULE_14]
	assign freq_fast = ~freq_slow & ~freq_mid;

	// The mid oscillator also runs whenever the fast one does, because it is the PLL reference.
	always_ff @(posedge clock) begin
		if (!resetn) begin
			osc_enables <= '0;
		end else begin
			osc_enables.fast_osc_enable            <= internal_active & freq_fast; // [RULE_15]
			osc_enables.mid_osc_enable             <= internal_active
				& (freq_mid | freq_fast); // [RULE_16] [RULE_10]
			osc_enables.slow_osc_enable            <= internal_active & freq_slow;
			osc_enables.fast_osc_multiplier_enable <= internal_active & freq_fast; // [RULE_10]
			osc_enables.fast_startup_osc_enable    <= internal_active & freq_fast
				& ~clock_status_reg.fast_osc_running; // [RULE_17]
		end
	end

	always_ff @(posedge clock) begin
		if (!resetn) begin
			system_clock_source <= css_pkg::SRC_PRIMARY;
		end else if (system_source_select[1]) begin
			system_clock_source <= css_pkg::SRC_INTERNAL; // [RULE_09]
		end else if (system_source_select[0]) begin
			system_clock_source <= css_pkg::SRC_AUX; // [RULE_06] [RULE_23]
		end else if (cfg_source_select == css_pkg::CFG_INTERNAL) begin
			system_clock_source <= css_pkg::SRC_INTERNAL; // [RULE_09]
		end else begin
			system_clock_source <= css_pkg::SRC_PRIMARY;
		end
	end

	// The trim reaches only the mid oscillator and its PLL product; the slow one has no trim.
	always_ff @(posedge clock) begin
		if (!resetn) begin
			postscaler_select <= css_pkg::RST_FREQ_SELECT;
			fast_mid_trim     <= css_pkg::RST_TRIM;
		end else begin
			postscaler_select <= internal_freq_select; // [RULE_13] [RULE_14]
			fast_mid_trim     <= freq_trim_reg; // [RULE_11] [RULE_12]
		end
	end

	always_ff @(posedge clock) begin
		if (!resetn) begin
			multiplier_enable         <= 1'b0;
			multiplier_input_internal <= 1'b0;
		end else begin
			multiplier_enable         <= cfg_multiplier_enable | sw_multiplier_enable; // [RULE_04]
			multiplier_input_internal <= internal_active
				| (cfg_source_select == css_pkg::CFG_INTERNAL); // [RULE_05]
		end
	end

	//////////////////////////////////////////////////////////////////////////////////////////////
	// Pin reuse.

	always_ff @(posedge clock) begin
		if (!resetn) begin
			osc_out_drives_clock <= 1'b0;
			osc_out_is_gpio      <= 1'b0;
			osc_in_is_gpio       <= 1'b0;
		end else begin
			osc_out_drives_clock <= ((cfg_source_select == css_pkg::CFG_RC)
				| (cfg_source_select == css_pkg::CFG_INTERNAL)) & cfg_clock_out_enable; // [RULE_07]
			osc_out_is_gpio      <= ((cfg_source_select == css_pkg::CFG_RC)
				| (cfg_source_select == css_pkg::CFG_INTERNAL)) & ~cfg_clock_out_enable; // [RULE_07]
			osc_in_is_gpio       <= (cfg_source_select == css_pkg::CFG_INTERNAL); // [RULE_08]
		end
	end

endmodule

// ### rtl/css_pkg.sv
package css_pkg;

	// Register byte offsets on the Avalon-MM slave.
	localparam logic [3:0] OFS_CONTROL = 4'h0;
	localparam logic [3:0] OFS_STATUS  = 4'h4;
	localparam logic [3:0] OFS_TRIM    = 4'h8;

	// Field positions in the control register.
	localparam int CTL_SRC_LSB  = 0;
	localparam int CTL_FREQ_LSB = 3;
	localparam int CTL_MULT_BIT = 7;

	// Field positions in the status register.
	localparam int STA_MID_RUN_BIT    = 0;
	localparam int STA_FAST_STAB_BIT  = 1;
	localparam int STA_FAST_LOCK_BIT  = 2;
	localparam int STA_FAST_RUN_BIT   = 3;
	localparam int STA_XTAL_READY_BIT = 4;
	localparam int STA_CPU_HOLD_BIT   = 5;

	// Reset values.
	localparam logic [3:0] RST_FREQ_SELECT = 4'h7;
	localparam logic [1:0] RST_SOURCE_SEL  = 2'h0;
	localparam logic       RST_SW_MULT     = 1'b0;
	localparam logic [5:0] RST_TRIM        = 6'h00;

	// Configuration source codes.
	localparam logic [2:0] CFG_LOW_POWER_XTAL = 3'h0;
	localparam logic [2:0] CFG_MEDIUM_XTAL    = 3'h1;
	localparam logic [2:0] CFG_HIGH_XTAL      = 3'h2;
	localparam logic [2:0] CFG_RC             = 3'h3;
	localparam logic [2:0] CFG_INTERNAL       = 3'h4;

	// Frequency select groups: slow source, then nine mid-derived codes, then fast.
	localparam logic [3:0] FREQ_SLOW_CODE  = 4'h0;
	localparam logic [3:0] FREQ_MID_FIRST  = 4'h1;
	localparam logic [3:0] FREQ_MID_LAST   = 4'h9;

	// Timing counts.
	localparam int CRYSTAL_SETTLE_EDGES = 1024;
	localparam int SETTLE_W             = 11;
	localparam int SYNC_STAGES          = 2;

	typedef enum logic [1:0] {
		SRC_PRIMARY  = 2'h0,
		SRC_AUX      = 2'h1,
		SRC_INTERNAL = 2'h2
	} css_src_e;

	typedef enum logic [3:0] {
		ST_POWER_UP = 4'b0001,
		ST_DELAY    = 4'b0010,
		ST_SETTLE   = 4'b0100,
		ST_RUN      = 4'b1000
	} css_state_e;

	typedef struct packed {
		logic fast_osc_running;
		logic fast_osc_near_lock;
		logic fast_osc_stable;
		logic mid_osc_running;
	} css_osc_flags_s;

	typedef struct packed {
		logic fast_osc_enable;
		logic mid_osc_enable;
		logic slow_osc_enable;
		logic fast_osc_multiplier_enable;
		logic fast_startup_osc_enable;
	} css_osc_enables_s;

endpackage

// ### bench/css_xtal_model.sv
module css_xtal_model (
	input  wire logic                    clock,
	input  wire logic                    resetn,
	input  wire logic                    start,
	input  wire logic [10:0]             rises,
	input  wire css_pkg::css_osc_enables_s osc_enables,
	output logic                         osc_in_pin,
	output logic                         busy,
	output css_pkg::css_osc_flags_s      osc_flags_raw
);
	logic [10:0] left;
	logic [1:0]  ph;
	logic [2:0]  fage;
	logic [1:0]  mage;

	// The crystal stands still between bursts, so only the requested cycles reach the pin.
	always_ff @(posedge clock) begin
		if (!resetn) begin
			left       <= 11'h000;
			ph         <= 2'h0;
			osc_in_pin <= 1'b0;
		end else if (start) begin
			left <= rises;
			ph   <= 2'h0;
		end else if (left != 11'h000) begin
			ph <= (ph == 2'h2) ? 2'h0 : ph + 2'h1;
			if (ph == 2'h2) begin
				osc_in_pin <= !osc_in_pin;
				if (osc_in_pin)
					left <= left - 11'h001;
			end
		end
	end

	assign busy = (left != 11'h000) || start;

	////////////////////////////////////////////////////////////////////////////////
	// Analog oscillators take a few cycles to run, then to lock and settle.
	always_ff @(posedge clock) begin
		fage <= !osc_enables.fast_osc_enable ? 3'h0 : (fage == 3'h7 ? fage : fage + 3'h1);
		mage <= !osc_enables.mid_osc_enable ? 2'h0 : (mage == 2'h3 ? mage : mage + 2'h1);
	end

	assign osc_flags_raw.fast_osc_running   = fage >= 3'h2;
	assign osc_flags_raw.fast_osc_near_lock = fage >= 3'h4;
	assign osc_flags_raw.fast_osc_stable    = fage >= 3'h6;
	assign osc_flags_raw.mid_osc_running    = mage >= 2'h2;
endmodule

// ### bench/css_clock_source_asserts.sv
module css_clock_source_asserts (
	input wire logic                       clock,
	input wire logic                       resetn,
	input wire logic                       avs_read,
	input wire logic                       avs_write,
	input wire logic                       avs_waitrequest,
	input wire logic [2:0]                 cfg_source_select,
	input wire logic                       cfg_multiplier_enable,
	input wire logic                       cfg_clock_out_enable,
	input wire logic                       wake_event,
	input wire logic                       osc_in_pin,
	input wire css_pkg::css_osc_enables_s  osc_enables,
	input wire css_pkg::css_src_e          system_clock_source,
	input wire logic [3:0]                 postscaler_select,
	input wire logic                       multiplier_enable,
	input wire logic                       cpu_hold,
	input wire logic                       crystal_clock_ready,
	input wire logic                       osc_out_drives_clock,
	input wire logic                       osc_out_is_gpio,
	input wire logic                       osc_in_is_gpio
);
	default clocking @(posedge clock); endclocking
	default disable iff (!resetn);

	logic [11:0] pin_rises;
	logic        pin_q;
	logic        intl;
	logic        rc_or_int;

	// Raw pin rises never lag the design's synchronised count, so they bound it from above.
	always_ff @(posedge clock) begin
		pin_q <= osc_in_pin;
		if (!resetn || wake_event)
			pin_rises <= 12'h000;
		else if (osc_in_pin && !pin_q && pin_rises != 12'hFFF)
			pin_rises <= pin_rises + 12'h001;
	end

	assign intl      = cfg_source_select == css_pkg::CFG_INTERNAL;
	assign rc_or_int = intl || cfg_source_select == css_pkg::CFG_RC;

	AST_ONE_WAIT: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
		else $error("bus request waited more than one cycle");
	AST_IDLE_NO_WAIT: assert property (!avs_read && !avs_write |-> !avs_waitrequest)
		else $error("waitrequest without a request");
	AST_CFG_MULT: assert property ($past(resetn) && $past(cfg_multiplier_enable) |-> multiplier_enable)
		else $error("multiplier off while config bit set");
	AST_IN_GPIO: assert property (intl ##1 intl |-> osc_in_is_gpio)
		else $error("input pin not released in internal mode");
	AST_CLKOUT: assert property (rc_or_int ##1 rc_or_int |->
		osc_out_drives_clock == cfg_clock_out_enable && osc_out_is_gpio == !cfg_clock_out_enable)
		else $error("output pin function does not follow clock-out bit");
	AST_EXT_NO_HOLD: assert property ($rose(resetn) && cfg_source_select >= 3'h5 |-> ##[1:3] !cpu_hold)
		else $error("external clock mode held execution");
	AST_XTAL_PAIR: assert property (cfg_source_select < 3'h3 |-> cpu_hold != crystal_clock_ready)
		else $error("hold and crystal ready disagree");
	AST_SETTLE_MIN: assert property ($fell(cpu_hold) && cfg_source_select < 3'h3 |-> pin_rises >= 12'd1024)
		else $error("crystal released before full count");
	AST_FAST_EN: assert property ($past(resetn) && $stable(postscaler_select) && $stable(system_clock_source) |->
		osc_enables.fast_osc_enable == (postscaler_select >= 4'hA &&
		(intl || system_clock_source == css_pkg::SRC_INTERNAL)))
		else $error("fast oscillator enable wrong");
	AST_MID_EN: assert property ($past(resetn) && $stable(postscaler_select) && $stable(system_clock_source) |->
		osc_enables.mid_osc_enable == (postscaler_select != 4'h0 &&
		(intl || system_clock_source == css_pkg::SRC_INTERNAL)))
		else $error("mid oscillator enable wrong");

	COV_RELEASE: cover property ($fell(cpu_hold) && cfg_source_select < 3'h3);
	COV_WAKE: cover property (wake_event ##3 cpu_hold);
	COV_AUX: cover property (system_clock_source == css_pkg::SRC_AUX);
	COV_FAST: cover property (osc_enables.fast_osc_enable);
endmodule

bind css_clock_source css_clock_source_asserts u_chk (.*);

// ### bench/css_clock_source_tb_top.sv
module css_clock_source_tb_top;
	timeunit 1ns;
	timeprecision 1ps;

	logic clock = 1'b0, resetn = 1'b0, avs_read = 1'b0, avs_write = 1'b0;
	logic [3:0] avs_address = 4'h0, avs_byteenable = 4'hF;
	logic [31:0] avs_writedata = 32'h0, avs_readdata, q;
	logic avs_waitrequest, cfg_multiplier_enable = 1'b0, cfg_clock_out_enable = 1'b1;
	logic [2:0] cfg_source_select = 3'h4;
	logic power_up_delay_enable = 1'b0, power_up_delay_expired = 1'b0, wake_event = 1'b0;
	logic osc_in_pin, busy, start = 1'b0, multiplier_enable, multiplier_input_internal;
	logic [10:0] rises = 11'h000;
	logic [3:0] postscaler_select;
	logic [5:0] fast_mid_trim;
	logic cpu_hold, crystal_clock_ready, osc_out_drives_clock, osc_out_is_gpio, osc_in_is_gpio;
	css_pkg::css_osc_flags_s osc_flags_raw;
	css_pkg::css_osc_enables_s osc_enables;
	css_pkg::css_src_e system_clock_source;
	int n_errors = 0, n_compared = 0;
	logic [3:0] corner [4] = '{4'h0, 4'h9, 4'hA, 4'hF};

	initial forever #12.5 clock = !clock;

	css_clock_source dut (.*);
	css_xtal_model u_xtal (.*);

	task automatic conclude();
		$display("compared %0d errors %0d", n_compared, n_errors);
		if (n_errors == 0 && n_compared > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask

	task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_compared++;
		if (g !== e) begin
			n_errors++;
			$display("unexpected %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
		int n;
		n = 0;
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= w;
		avs_read <= !w;
		@(posedge clock);
		while (avs_waitrequest !== 1'b0 && n < 50) begin
			@(posedge clock);
			n++;
		end
		if (n >= 50) check("bus timeout", 32'h1, 32'h0);
		q = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		@(posedge clock);
	endtask

	task automatic do_reset(input logic [2:0] cfg, input logic pde, input logic cm);
		cfg_source_select <= cfg;
		power_up_delay_enable <= pde;
		cfg_multiplier_enable <= cm;
		resetn <= 1'b0;
		repeat (5) @(posedge clock);
		resetn <= 1'b1;
		repeat (2) @(posedge clock);
	endtask

	task automatic settle(input logic [10:0] n);
		start <= 1'b1;
		rises <= n;
		@(posedge clock);
		start <= 1'b0;
		@(posedge clock);
		while (busy) @(posedge clock);
		repeat (8) @(posedge clock);
	endtask

	// Expected clock enables follow the select code and the source condition.
	task automatic run_random(input int n);
		logic [3:0] fr;
		logic [1:0] sr;
		logic sw, fe, me, cond;
		logic [5:0] tr;
		for (int i = 0; i < n; i++) begin
			fr = (i < 4) ? corner[i] : 4'($urandom);
			sr = (i < 4) ? 2'(i) : 2'($urandom);
			sw = 1'($urandom);
			tr = 6'($urandom);
			bus(1'b1, css_pkg::OFS_CONTROL, {24'h0, sw, fr, 1'b0, sr});
			bus(1'b1, css_pkg::OFS_TRIM, {26'h0, tr});
			repeat (16) @(posedge clock);
			cond = cfg_source_select == css_pkg::CFG_INTERNAL || sr[1];
			fe = fr >= 4'hA && cond;
			me = fr != 4'h0 && cond;
			check("postscaler", fr, postscaler_select);
			check("source", cond && sr != 2'h1 ? 2 : sr, system_clock_source);
			check("multiplier", sw, multiplier_enable);
			check("trim", tr, fast_mid_trim);
			check("fast enable", fe, osc_enables.fast_osc_enable);
			check("mid enable", me, osc_enables.mid_osc_enable);
			check("slow en", fr == 4'h0 && cond, osc_enables.slow_osc_enable);
			check("pll en", fe, osc_enables.fast_osc_multiplier_enable);
			check("startup en", 0, osc_enables.fast_startup_osc_enable);
			check("mult input", cond, multiplier_input_internal);
			bus(1'b0, css_pkg::OFS_STATUS, 32'h0);
			check("status", {28'h0, fe, fe, fe, me}, q & 32'hF);
			bus(1'b0, css_pkg::OFS_CONTROL, 32'h0);
			check("control", {24'h0, sw, fr, 1'b0, sr}, q);
		end
	endtask

	initial begin
		void'($urandom(32'h36de));
		do_reset(css_pkg::CFG_INTERNAL, 1'b0, 1'b0);
		check("postscaler reset", 32'h7, postscaler_select);
		bus(1'b0, css_pkg::OFS_CONTROL, 32'h0);
		check("control reset", 32'h38, q);
		bus(1'b0, css_pkg::OFS_TRIM, 32'h0);
		check("trim reset", 32'h0, q);
		bus(1'b0, 4'hC, 32'h0);
		check("unmapped", 32'h0, q);
		check("hold internal", 32'h0, cpu_hold);
		check("in gpio", 32'h1, osc_in_is_gpio);
		check("clock out", 32'h1, osc_out_drives_clock);
		run_random(16);
		bus(1'b1, css_pkg::OFS_CONTROL, 32'h38);
		avs_byteenable <= 4'h0;
		bus(1'b1, css_pkg::OFS_CONTROL, 32'h0);
		avs_byteenable <= 4'hF;
		bus(1'b0, css_pkg::OFS_CONTROL, 32'h0);
		check("lane dropped", 32'h38, q);
		cfg_clock_out_enable <= 1'b0;
		do_reset(css_pkg::CFG_RC, 1'b0, 1'b0);
		check("out gpio", 32'h1, osc_out_is_gpio);
		check("in used", 32'h0, osc_in_is_gpio);
		run_random(6);
		do_reset(css_pkg::CFG_MEDIUM_XTAL, 1'b0, 1'b0);
		settle(11'd1023);
		check("hold at 1023", 32'h1, cpu_hold);
		settle(11'd1);
		check("hold at 1024", 32'h0, cpu_hold);
		check("ready", 32'h1, crystal_clock_ready);
		wake_event <= 1'b1;
		@(posedge clock);
		wake_event <= 1'b0;
		repeat (3) @(posedge clock);
		check("hold on wake", 32'h1, cpu_hold);
		settle(11'd1024);
		check("wake release", 32'h0, cpu_hold);
		do_reset(css_pkg::CFG_LOW_POWER_XTAL, 1'b1, 1'b0);
		settle(11'd1100);
		check("hold in delay", 32'h1, cpu_hold);
		power_up_delay_expired <= 1'b1;
		settle(11'd1024);
		check("delay release", 32'h0, cpu_hold);
		power_up_delay_expired <= 1'b0;
		do_reset(3'h5, 1'b0, 1'b1);
		check("external hold", 32'h0, cpu_hold);
		bus(1'b1, css_pkg::OFS_CONTROL, 32'h01);
		repeat (3) @(posedge clock);
		check("cfg multiplier", 32'h1, multiplier_enable);
		check("aux source", 32'h1, system_clock_source);
		conclude();
	end

	initial begin
		repeat (80000) @(posedge clock);
		n_errors++;
		conclude();
	end
endmodule
